// ===== hw/io_expander_pkg.sv
// constants for the eight-bit two-wire io expander
// assumes a 10 MHz logic clock and a slow serial link sampled by it
package io_expander_pkg;
  localparam logic [3:0] ADDR_FIXED_NIBBLE = 4'h4;
  localparam logic [1:0] REG_PIN_LEVEL_IN  = 2'h0;
  localparam logic [1:0] REG_PIN_DRIVE_OUT = 2'h1;
  localparam logic [1:0] REG_INPUT_INVERT  = 2'h2;
  localparam logic [1:0] REG_PIN_DIRECTION = 2'h3;
  localparam logic [7:0] RST_PIN_DRIVE_OUT = 8'hFF;
  localparam logic [7:0] RST_INPUT_INVERT  = 8'h00;
  localparam logic [7:0] RST_PIN_DIRECTION = 8'hFF;
  localparam logic [7:0] RST_POINTER       = 8'h00;
  localparam int         RW_BIT_POS        = 0;
  localparam logic       RW_READ           = 1'b1;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_ADDR  = 3'b001,
    ST_AACK  = 3'b011,
    ST_RX    = 3'b010,
    ST_RACK  = 3'b110,
    ST_TX    = 3'b111,
    ST_TACK  = 3'b101,
    ST_SKIP  = 3'b100
  } serial_state_e;
endpackage

// ===== hw/io_expander.sv
// two-wire target with four eight-bit port registers and an interrupt
// assumes link pins and port pins are asynchronous; pads resolve the enables
`timescale 1ns/10ps
module io_expander
  import io_expander_pkg::*;
#(
  parameter int PORT_WIDTH = 8
) (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  srst,
  // straps
  input  wire logic                  strap_sel_bit0,
  input  wire logic                  strap_sel_bit1,
  input  wire logic                  strap_sel_bit2,
  // serial link
  input  wire logic                  scl_in,
  input  wire logic                  sda_in,
  output logic                       sda_out,
  output logic                       sda_oe_n,
  // port pins
  input  wire logic [PORT_WIDTH-1:0] port_pins_in,
  output logic [PORT_WIDTH-1:0]      port_pins_out,
  output logic [PORT_WIDTH-1:0]      port_pins_oe_n,
  // interrupt, open drain
  output logic                       int_out,
  output logic                       int_oe_n
);

  // ==========================================================
  // synchronisers
  logic [1:0]            scl_sync_reg;
  logic [1:0]            sda_sync_reg;
  logic                  scl_prev_reg;
  logic                  sda_prev_reg;
  logic [PORT_WIDTH-1:0] pin_meta_reg;
  logic [PORT_WIDTH-1:0] pin_sync_reg;
  logic [2:0]            strap_meta_reg;
  logic [2:0]            strap_sync_reg;

  always_ff @(posedge clk) begin
    scl_sync_reg   <= {scl_sync_reg[0], scl_in};
    sda_sync_reg   <= {sda_sync_reg[0], sda_in};
    scl_prev_reg   <= scl_sync_reg[1];
    sda_prev_reg   <= sda_sync_reg[1];
    pin_meta_reg   <= port_pins_in;
    pin_sync_reg   <= pin_meta_reg;
    strap_meta_reg <= {strap_sel_bit2, strap_sel_bit1, strap_sel_bit0};
    strap_sync_reg <= strap_meta_reg;
  end

  logic scl_s;
  logic sda_s;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  assign scl_s     = scl_sync_reg[1];
  assign sda_s     = sda_sync_reg[1];
  assign scl_rise  = scl_s & ~scl_prev_reg;
  assign scl_fall  = ~scl_s & scl_prev_reg;
  assign start_det = scl_s & scl_prev_reg & sda_prev_reg & ~sda_s;
  assign stop_det  = scl_s & scl_prev_reg & ~sda_prev_reg & sda_s;

  // ==========================================================
  // registers
  logic [7:0]            pointer_reg;
  logic [PORT_WIDTH-1:0] pin_drive_out_reg;
  logic [PORT_WIDTH-1:0] input_invert_reg;
  logic [PORT_WIDTH-1:0] pin_direction_reg;
  logic [PORT_WIDTH-1:0] level_view;
  logic [PORT_WIDTH-1:0] read_mux;

  assign level_view = pin_sync_reg ^ input_invert_reg;

  always_comb begin
    case (pointer_reg[1:0])
      REG_PIN_LEVEL_IN:  read_mux = level_view;
      REG_PIN_DRIVE_OUT: read_mux = pin_drive_out_reg;
      REG_INPUT_INVERT:  read_mux = input_invert_reg;
      REG_PIN_DIRECTION: read_mux = pin_direction_reg;
      default:           read_mux = level_view;
    endcase
  end

  // ==========================================================
  // serial engine
  serial_state_e state_reg;
  logic [7:0]    shift_reg;
  logic [2:0]    bit_cnt_reg;
  logic          is_read_reg;
  logic          have_cmd_reg;
  logic          sda_low_reg;
  logic          byte_done_pulse;
  logic [7:0]    rx_byte;
  logic          addr_match;

  assign rx_byte    = {shift_reg[6:0], sda_s};
  assign addr_match = (rx_byte[7:4] == ADDR_FIXED_NIBBLE) && (rx_byte[3:1] == strap_sync_reg);

  logic load_pulse;
  logic wr_pulse;
  logic cmd_pulse;
  logic in_read_ack;

  // sampled on scl rise: last data bit, the address ack bit of a read, or the master's ack bit
  assign byte_done_pulse = scl_rise && (bit_cnt_reg == 3'h7);
  assign cmd_pulse  = byte_done_pulse && (state_reg == ST_RX) && !have_cmd_reg;
  assign wr_pulse   = byte_done_pulse && (state_reg == ST_RX) && have_cmd_reg;
  assign load_pulse = scl_rise && ((state_reg == ST_AACK && is_read_reg) ||
                                   (state_reg == ST_TACK && !sda_s));
  assign in_read_ack = scl_rise && (state_reg == ST_TACK);

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg    <= ST_IDLE;
      bit_cnt_reg  <= 3'h0;
      shift_reg    <= 8'h00;
      is_read_reg  <= 1'b0;
      have_cmd_reg <= 1'b0;
    end else if (stop_det) begin
      state_reg <= ST_IDLE;
    end else if (start_det) begin
      state_reg   <= ST_ADDR;
      bit_cnt_reg <= 3'h0;
    end else begin
      case (state_reg)
        ST_IDLE: state_reg <= ST_IDLE;
        ST_ADDR: if (scl_rise) begin
          shift_reg   <= rx_byte;
          bit_cnt_reg <= bit_cnt_reg + 3'h1;
          if (bit_cnt_reg == 3'h7) begin
            is_read_reg  <= (rx_byte[RW_BIT_POS] == RW_READ);
            have_cmd_reg <= 1'b0;
            state_reg    <= addr_match ? ST_AACK : ST_SKIP;
          end
        end
        ST_AACK: if (scl_fall && !scl_prev_reg) begin
          state_reg <= state_reg;
        end else if (load_pulse) begin
          shift_reg <= read_mux;
          state_reg <= ST_TX;
        end else if (scl_rise) begin
          state_reg <= ST_RX;
        end
        ST_RX: if (scl_rise) begin
          shift_reg   <= rx_byte;
          bit_cnt_reg <= bit_cnt_reg + 3'h1;
          if (bit_cnt_reg == 3'h7) begin
            have_cmd_reg <= 1'b1;
            state_reg    <= ST_RACK;
          end
        end
        ST_RACK: if (scl_rise) begin
          state_reg <= ST_RX;
        end
        ST_TX: if (scl_rise) begin
          bit_cnt_reg <= bit_cnt_reg + 3'h1;
          if (bit_cnt_reg == 3'h7) begin
            state_reg <= ST_TACK;
          end
        end
        ST_TACK: if (load_pulse) begin
          shift_reg <= read_mux;
          state_reg <= ST_TX;
        end else if (scl_rise) begin
          state_reg <= ST_SKIP;
        end
        ST_SKIP: state_reg <= ST_SKIP;
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // shift out on scl fall during transmit
  logic [7:0] tx_shift_reg;
  always_ff @(posedge clk) begin
    if (srst) begin
      tx_shift_reg <= 8'hFF;
    end else if (load_pulse) begin
      tx_shift_reg <= read_mux;
    end else if (scl_fall && state_reg == ST_TX) begin
      tx_shift_reg <= {tx_shift_reg[6:0], 1'b1};
    end
  end

  // sda drive is set only on scl fall so data is stable while scl high; start and stop detection release it
  always_ff @(posedge clk) begin
    if (srst || stop_det || start_det) begin
      sda_low_reg <= 1'b0;
    end else if (scl_fall) begin
      case (state_reg)
        // a matched address is acknowledged for reads and writes alike
        ST_AACK: sda_low_reg <= 1'b1;
        ST_RACK: sda_low_reg <= 1'b1;
        ST_TX:   sda_low_reg <= !tx_shift_reg[7];
        default: sda_low_reg <= 1'b0;
      endcase
    end
  end

  // ack must appear at the fall after the eighth bit, before state moves
  logic ack_pending_reg;
  always_ff @(posedge clk) begin
    if (srst || stop_det || start_det) begin
      ack_pending_reg <= 1'b0;
    end else if (scl_fall) begin
      ack_pending_reg <= (state_reg == ST_AACK && !is_read_reg) || state_reg == ST_RACK ||
                         (state_reg == ST_AACK && is_read_reg);
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      sda_out  <= 1'b0;
      sda_oe_n <= 1'b1;
    end else begin
      sda_out  <= 1'b0;
      sda_oe_n <= ~(sda_low_reg | ack_pending_reg);
    end
  end

  // ==========================================================
  // register writes
  // pointer
  always_ff @(posedge clk) begin
    if (srst) begin
      pointer_reg <= RST_POINTER;
    end else if (cmd_pulse) begin
      pointer_reg <= rx_byte;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      pin_drive_out_reg <= RST_PIN_DRIVE_OUT;
      input_invert_reg  <= RST_INPUT_INVERT;
      pin_direction_reg <= RST_PIN_DIRECTION;
    end else if (wr_pulse) begin
      case (pointer_reg[1:0])
        REG_PIN_DRIVE_OUT: pin_drive_out_reg <= rx_byte;
        REG_INPUT_INVERT:  input_invert_reg  <= rx_byte;
        REG_PIN_DIRECTION: pin_direction_reg <= rx_byte;
        default:           pin_drive_out_reg <= pin_drive_out_reg;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      port_pins_out  <= RST_PIN_DRIVE_OUT;
      port_pins_oe_n <= RST_PIN_DIRECTION;
    end else begin
      port_pins_out  <= pin_drive_out_reg;
      port_pins_oe_n <= pin_direction_reg;
    end
  end

  // ==========================================================
  // interrupt
  logic [PORT_WIDTH-1:0] snap_reg;
  logic                  snap_valid_reg;
  logic                  mismatch;

  assign mismatch = snap_valid_reg && |((pin_sync_reg ^ snap_reg) & pin_direction_reg);

  // snapshot refreshed on input register read ack
  always_ff @(posedge clk) begin
    if (srst) begin
      snap_reg       <= '0;
      snap_valid_reg <= 1'b0;
    end else if (!snap_valid_reg || (in_read_ack && pointer_reg[1:0] == REG_PIN_LEVEL_IN)) begin
      snap_reg       <= pin_sync_reg;
      snap_valid_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      int_out  <= 1'b0;
      int_oe_n <= 1'b1;
    end else begin
      int_out  <= 1'b0;
      int_oe_n <= ~mismatch;
    end
  end

endmodule

// ===== test/io_expander_sva.sv
// assertions on the io expander ports
// assumes the bind at the foot of this file
`timescale 1ns/10ps
module io_expander_sva #(
  parameter int PORT_WIDTH = 8
) (
  // clock and reset
  input wire logic                  clk,
  input wire logic                  srst,
  // serial link
  input wire logic                  scl_in,
  input wire logic                  sda_in,
  input wire logic                  sda_out,
  input wire logic                  sda_oe_n,
  // port pins and interrupt
  input wire logic [PORT_WIDTH-1:0] port_pins_in,
  input wire logic [PORT_WIDTH-1:0] port_pins_out,
  input wire logic [PORT_WIDTH-1:0] port_pins_oe_n,
  input wire logic                  int_out,
  input wire logic                  int_oe_n
);
  // ====
  // idle count of input-mode pins, saturating
  logic [PORT_WIDTH-1:0] seen_in_reg;
  logic [3:0]            quiet_cnt_reg;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  always_ff @(posedge clk) begin
    seen_in_reg <= port_pins_in & port_pins_oe_n;
  end
  always_ff @(posedge clk) begin
    if (srst || seen_in_reg != (port_pins_in & port_pins_oe_n)) begin
      quiet_cnt_reg <= 4'h0;
    end else if (quiet_cnt_reg != 4'hF) begin
      quiet_cnt_reg <= quiet_cnt_reg + 4'h1;
    end
  end
  a_reset_defaults: assert property (
    $fell(srst) |-> port_pins_out == {PORT_WIDTH{1'b1}} && port_pins_oe_n == {PORT_WIDTH{1'b1}} && sda_oe_n)
    else $error("outputs not at defaults after reset");
  a_release_on_stop: assert property (
    scl_in && $past(scl_in) && $rose(sda_in) |=> sda_oe_n [*8])
    else $error("data line driven after stop");
  a_drive_scl_low: assert property (
    $fell(sda_oe_n) |-> !$past(scl_in))
    else $error("data drive began while clock high");
  a_hold_scl_high: assert property (
    scl_in && $past(scl_in) && $past(scl_in, 2) |-> $stable(sda_oe_n))
    else $error("data drive changed while clock high");
  a_out_change_acked: assert property (
    $changed(port_pins_out) |-> ##[1:12] $fell(sda_oe_n))
    else $error("output change without byte acknowledge");
  a_dir_change_acked: assert property (
    $changed(port_pins_oe_n) |-> ##[1:12] $fell(sda_oe_n))
    else $error("direction change without byte acknowledge");
  a_int_needs_change: assert property (
    $fell(int_oe_n) |-> quiet_cnt_reg < 4'h8)
    else $error("interrupt without input pin change");
  a_drives_low: assert property (
    1'b1 |-> !int_out && !sda_out)
    else $error("open drain output drives high");
  c_ack: cover property ($fell(sda_oe_n));
  c_int: cover property ($fell(int_oe_n));
  c_out_write: cover property ($changed(port_pins_out));
endmodule
bind io_expander io_expander_sva #(.PORT_WIDTH(PORT_WIDTH)) io_expander_sva_i (.clk(clk), .srst(srst),
  .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .port_pins_in(port_pins_in),
  .port_pins_out(port_pins_out), .port_pins_oe_n(port_pins_oe_n), .int_out(int_out), .int_oe_n(int_oe_n));

// ===== test/bus_ctl_model.sv
// two-wire bus controller model: start, stop and byte tasks
// assumes the bench resolves sda with a pull-up; outputs change at clk fall
`timescale 1ns/10ps
module bus_ctl_model (
  // clock and resolved data line
  input  wire logic clk,
  input  wire logic sda,
  // controller drives, high when released
  output logic      scl,
  output logic      sda_drv
);
  // ====
  // bus phases: five clocks low, three high, 800 ns a bit
  initial begin
    scl = 1'b1;
    sda_drv = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic phase(input logic b);
    tick(1);
    sda_drv = b;
    tick(4);
    scl = 1'b1;
    tick(3);
  endtask
  task automatic start();
    phase(1'b1);
    sda_drv = 1'b0;
    tick(3);
    scl = 1'b0;
  endtask
  // stop may come after any byte
  task automatic stop();
    phase(1'b0);
    sda_drv = 1'b1;
    tick(4);
  endtask
  task automatic bit_xfer(input logic b, output logic s);
    phase(b);
    s = sda;
    scl = 1'b0;
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_xfer(d[i], s);
    bit_xfer(1'b1, s);
    ack = ~s;
  endtask
  // last byte answered with no acknowledge
  task automatic rbyte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_xfer(1'b1, d[i]);
    bit_xfer(last, s);
  endtask
endmodule

// ===== test/io_expander_test.sv
// self-checking bench for the io expander through its two-wire port
// assumes bus_ctl_model drives the link; straps give address 0x25
`timescale 1ns/10ps
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_mismatch++; \
  $display("[ERR] t=%0t got %h exp %h", $time, (a), (e)); end end
module io_expander_test
  import io_expander_pkg::*;
;
  localparam logic [6:0] DEV = {ADDR_FIXED_NIBBLE, 3'h5};
  logic       clk = 1'b0;
  logic       srst = 1'b1;
  logic       ack;
  logic [7:0] ext_in = 8'h96;
  logic [7:0] rd;
  int         n_mismatch = 0;
  int         check_count = 0;
  wire        scl, sda_drv, sda_out, sda_oe_n, int_out, int_oe_n;
  wire  [7:0] pins_out, pins_oe_n;
  wire        sda = sda_drv & (sda_oe_n | sda_out);
  wire  [7:0] pins = (ext_in & pins_oe_n) | (pins_out & ~pins_oe_n);
  always #50 clk = ~clk;
  io_expander io_expander_i (.clk(clk), .srst(srst), .strap_sel_bit0(1'b1), .strap_sel_bit1(1'b0),
    .strap_sel_bit2(1'b1), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
    .port_pins_in(pins), .port_pins_out(pins_out), .port_pins_oe_n(pins_oe_n), .int_out(int_out),
    .int_oe_n(int_oe_n));
  bus_ctl_model bus_ctl_model_i (.clk(clk), .sda(sda), .scl(scl), .sda_drv(sda_drv));
  // ====
  // access tasks
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic addr(input logic rw);
    bus_ctl_model_i.start();
    bus_ctl_model_i.wbyte({DEV, rw}, ack);
    `CHK(ack, 1'b1)
  endtask
  task automatic wr_reg(input logic [7:0] cmd, input logic [7:0] d);
    addr(1'b0);
    bus_ctl_model_i.wbyte(cmd, ack);
    bus_ctl_model_i.wbyte(d, ack);
    `CHK(ack, 1'b1)
    bus_ctl_model_i.stop();
  endtask
  task automatic rd_cur(input logic [7:0] e);
    addr(1'b1);
    bus_ctl_model_i.rbyte(1'b1, rd);
    bus_ctl_model_i.stop();
    `CHK(rd, e)
  endtask
  task automatic rd_reg(input logic [7:0] cmd, input logic [7:0] e);
    addr(1'b0);
    bus_ctl_model_i.wbyte(cmd, ack);
    rd_cur(e);
  endtask
  task automatic wait_int(input logic lvl);
    for (int i = 0; i < 20 && int_oe_n !== lvl; i++) @(negedge clk);
    `CHK(int_oe_n, lvl)
    if (int_oe_n !== lvl) tally_and_finish();
  endtask
  initial begin
    repeat (16) @(negedge clk);
    srst = 1'b0;
    repeat (4) @(negedge clk);
    `CHK(pins_out, 8'hFF)
    `CHK(pins_oe_n, 8'hFF)
    rd_reg(8'h02, 8'h00);
    rd_reg(8'h03, 8'hFF);
    rd_reg(8'h01, 8'hFF);
    bus_ctl_model_i.start();
    bus_ctl_model_i.wbyte({ADDR_FIXED_NIBBLE, 4'h8}, ack);
    bus_ctl_model_i.stop();
    `CHK(ack, 1'b0)
    $display("test defaults and address done");
    wr_reg(8'h03, 8'h0F);
    addr(1'b0);
    bus_ctl_model_i.wbyte(8'h01, ack);
    bus_ctl_model_i.wbyte(8'h3C, ack);
    bus_ctl_model_i.wbyte(8'hA5, ack);
    bus_ctl_model_i.stop();
    `CHK(pins_oe_n, 8'h0F)
    `CHK(pins_out, 8'hA5)
    rd_reg(8'h00, 8'hA6);
    $display("test burst write done");
    ext_in = 8'h16;
    repeat (10) @(negedge clk);
    `CHK(int_oe_n, 1'b1)
    ext_in = 8'h17;
    wait_int(1'b0);
    ext_in = 8'h16;
    wait_int(1'b1);
    ext_in = 8'h17;
    wait_int(1'b0);
    rd_cur(8'hA7);
    `CHK(int_oe_n, 1'b1)
    $display("test interrupt done");
    wr_reg(8'h02, 8'hF0);
    rd_reg(8'h00, 8'h57);
    wr_reg(8'h00, 8'h55);
    rd_reg(8'h01, 8'hA5);
    rd_reg(8'h00, 8'h57);
    rd_cur(8'h57);
    addr(1'b1);
    ext_in = 8'h16;
    bus_ctl_model_i.rbyte(1'b0, rd);
    `CHK(rd, 8'h57)
    bus_ctl_model_i.rbyte(1'b1, rd);
    bus_ctl_model_i.stop();
    `CHK(rd, 8'h56)
    $display("test invert and read burst done");
    addr(1'b0);
    bus_ctl_model_i.wbyte(8'h02, ack);
    bus_ctl_model_i.stop();
    rd_cur(8'hF0);
    srst = 1'b1;
    repeat (4) @(negedge clk);
    srst = 1'b0;
    repeat (4) @(negedge clk);
    `CHK(pins_oe_n, 8'hFF)
    rd_reg(8'h02, 8'h00);
    $display("test stop and reset done");
    tally_and_finish();
  end
endmodule
